//--- rtl/als_map.svh
// Register offsets, field positions, reset values and bus constants of the light sensor.
`ifndef ALS_MAP_SVH
`define ALS_MAP_SVH
`define SLAVE_ADDR 7'h10
`define CMD_LIGHT_CONFIG 8'h00
`define CMD_UPPER_BOUND 8'h01
`define CMD_LOWER_BOUND 8'h02
`define CMD_POWER_SAVING 8'h03
`define CMD_AMBIENT 8'h04
`define CMD_WHITE 8'h05
`define CMD_STATUS 8'h06
`define CMD_IDENT 8'h07
`define LIGHT_CONFIG_RESET 16'h0001
`define WINDOW_BOUND_RESET 16'h0000
`define POWER_SAVING_RESET 3'h0
`define STATUS_LOW_BIT 15
`define STATUS_HIGH_BIT 14
`define DEVICE_CODE_DEFAULT 8'h5a
`define ADDR_OPTION_DEFAULT 8'h3c
`define BYTE_BITS 4'h8
`define SCL_MIN_KHZ 10
`define SCL_MAX_KHZ 400
`endif

//--- rtl/als_measure.sv
// Result holding, shutdown retention and threshold persistence of the light sensor.
`timescale 1ns/1ps
module als_measure (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input als_pkg::light_config_s i_cfg,
	input wire logic [15:0] i_upper_window_bound,
	input wire logic [15:0] i_lower_window_bound,
	input als_pkg::sample_s i_sample,
	input wire logic i_status_clear,
	output als_pkg::result_s o_result
);
	als_pkg::measure_s r;
	als_pkg::measure_s r_nxt;
	logic [3:0] need;

	// Counts consecutive out-of-window samples, saturating at the needed count.
	function automatic logic [3:0] run_step(input logic [3:0] run, input logic outside,
			input logic [3:0] limit);
		logic [3:0] res;
		res = 4'h0;
		if (outside) begin
			res = (run == limit) ? limit : run + 4'h1;
		end
		return res;
	endfunction : run_step

	always_comb begin
		r_nxt = r;
		need = 4'h1 << i_cfg.persistence_count;
		if (i_status_clear) begin
			r_nxt.res.low_crossing_flag = 1'b0;
			r_nxt.res.high_crossing_flag = 1'b0;
		end
		// Samples are dropped in shutdown, so the last result stays readable.
		if (i_sample.valid && !i_cfg.shutdown_control) begin
			r_nxt.res.ambient_result = i_sample.ambient;
			r_nxt.res.white_result = i_sample.white;
			if (i_cfg.threshold_detect_enable) begin
				r_nxt.high_run = run_step(r.high_run, i_sample.ambient > i_upper_window_bound,
					need);
				r_nxt.low_run = run_step(r.low_run, i_sample.ambient < i_lower_window_bound,
					need);
				// A new event wins over a clear in the same cycle.
				if (r_nxt.high_run == need) begin
					r_nxt.res.high_crossing_flag = 1'b1;
				end
				if (r_nxt.low_run == need) begin
					r_nxt.res.low_crossing_flag = 1'b1;
				end
			end else begin
				r_nxt.high_run = 4'h0;
				r_nxt.low_run = 4'h0;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign o_result = r.res;
endmodule : als_measure

//--- rtl/als_pin_sync.sv
// Two-stage synchroniser for the serial clock and data pins.
`timescale 1ns/1ps
module als_pin_sync (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input als_pkg::pin_pair_s i_pins,
	output als_pkg::pin_pair_s o_pins
);
	als_pkg::sync_s r;
	als_pkg::sync_s r_nxt;

	always_comb begin
		r_nxt = r;
		r_nxt.meta = i_pins;
		r_nxt.stable = r.meta;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '1;
		end else begin
			r <= r_nxt;
		end
	end

	assign o_pins = r.stable;
endmodule : als_pin_sync

//--- rtl/als_pkg.sv
// Types shared by the light sensor register interface and its measurement control.
package als_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK
	} slave_state_e;

	typedef struct packed {
		logic scl;
		logic sda;
	} pin_pair_s;

	typedef struct packed {
		pin_pair_s meta;
		pin_pair_s stable;
	} sync_s;

	typedef struct packed {
		logic [2:0] reserved_hi;
		logic [1:0] gain_select;
		logic reserved_mid;
		logic [3:0] integration_time_select;
		logic [1:0] persistence_count;
		logic [1:0] reserved_lo;
		logic threshold_detect_enable;
		logic shutdown_control;
	} light_config_s;

	typedef struct packed {
		logic [1:0] power_saving_select;
		logic power_saving_enable;
	} power_saving_s;

	typedef struct packed {
		logic valid;
		logic [15:0] ambient;
		logic [15:0] white;
	} sample_s;

	typedef struct packed {
		logic [15:0] ambient_result;
		logic [15:0] white_result;
		logic low_crossing_flag;
		logic high_crossing_flag;
	} result_s;

	typedef struct packed {
		result_s res;
		logic [3:0] high_run;
		logic [3:0] low_run;
	} measure_s;

	typedef struct packed {
		slave_state_e state;
		logic [3:0] bit_cnt;
		logic [7:0] shreg;
		logic rw;
		logic [7:0] cmd;
		logic cmd_seen;
		logic byte_hi;
		logic [7:0] wlow;
		logic [7:0] tx;
		logic [7:0] tx_hi;
		logic sda_oe_n;
		logic sda_out;
		logic scl_prev;
		logic sda_prev;
		logic status_clear;
		light_config_s light_config;
		logic [15:0] upper_window_bound;
		logic [15:0] lower_window_bound;
		power_saving_s power_saving_control;
	} slave_s;
endpackage : als_pkg

//--- rtl/ambient_light_i2c_regs.sv
// Serial bus slave and command-code register file of the ambient light sensor.
// How it works
// - Only slave address 0x10 is acknowledged; other addresses are ignored.
// - Address byte bit 0 picks direction: 20h writes, 21h reads.
// - Oversampled bus works for serial clock from 10 kHz to 400 kHz.
// - All command-code registers are 16 bits, addressed by command code.
// - Shutdown keeps the last ambient result readable over the bus.
// - Leaving shutdown lets new measurements overwrite the result registers.
// - No interrupt pin; threshold events show only in the status register.
// - Configuration register resets to 0001, so the device starts shut down.
// - Configuration bits 12:11 select gain x1, x2, x1/8, x1/4.
// - Configuration bits 9:6 select integration time from 25 to 800 ms.
// - Configuration bits 5:4 set persistence count 1, 2, 4 or 8.
// - Configuration bit 1 enables threshold event detection.
// - Configuration bit 0 high shuts measurement down, low runs it.
// - Code 01h holds the upper threshold window bound, read and write.
// - Code 02h holds the lower threshold window bound, read and write.
// - Code 04 returns the ambient result, read only.
// - Code 05 returns the white channel result, read only.
// - Code 06 is the read-only threshold event status register.
// - Status bit 15 flags low crossing, bit 14 high crossing, rest zero.
// - Power saving bits 2:1 select mode, bit 0 enables power saving.
// - Code 07 reads device code in low byte, address option code high.
`timescale 1ns/1ps
`include "als_map.svh"
module ambient_light_i2c_regs #(
	parameter logic [7:0] DEVICE_CODE = `DEVICE_CODE_DEFAULT,
	parameter logic [7:0] ADDR_OPTION_CODE = `ADDR_OPTION_DEFAULT
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	input als_pkg::sample_s i_sample,
	output logic o_shutdown,
	output logic [1:0] o_gain_select,
	output logic [3:0] o_integration_time_select,
	output logic [1:0] o_power_saving_select,
	output logic o_power_saving_enable
);
	// Both identification codes are arbitrary values.
	als_pkg::slave_s r;
	als_pkg::slave_s r_nxt;
	als_pkg::pin_pair_s raw_pins;
	als_pkg::pin_pair_s pins;
	als_pkg::result_s result;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [15:0] rd_word;

	// Returns the 16-bit word at a command code; unmapped codes read as zero.
	function automatic logic [15:0] reg_read(input logic [7:0] cmd, input als_pkg::slave_s s,
			input als_pkg::result_s res);
		logic [15:0] word;
		word = 16'h0000;
		if (cmd == `CMD_LIGHT_CONFIG) begin
			word = s.light_config;
		end else if (cmd == `CMD_UPPER_BOUND) begin
			word = s.upper_window_bound;
		end else if (cmd == `CMD_LOWER_BOUND) begin
			word = s.lower_window_bound;
		end else if (cmd == `CMD_POWER_SAVING) begin
			word = {13'h0000, s.power_saving_control};
		end else if (cmd == `CMD_AMBIENT) begin
			word = res.ambient_result;
		end else if (cmd == `CMD_WHITE) begin
			word = res.white_result;
		end else if (cmd == `CMD_STATUS) begin
			word[`STATUS_LOW_BIT] = res.low_crossing_flag;
			word[`STATUS_HIGH_BIT] = res.high_crossing_flag;
		end else if (cmd == `CMD_IDENT) begin
			word = {ADDR_OPTION_CODE, DEVICE_CODE};
		end
		return word;
	endfunction : reg_read

	// Moves one sampled data bit into the receive shift register.
	function automatic als_pkg::slave_s shift_in(input als_pkg::slave_s s, input logic bit_in);
		als_pkg::slave_s n;
		n = s;
		n.shreg = {s.shreg[6:0], bit_in};
		n.bit_cnt = s.bit_cnt + 4'h1;
		return n;
	endfunction : shift_in

	// Snapshots a whole read word so both of its bytes belong to one value.
	function automatic als_pkg::slave_s load_word(input als_pkg::slave_s s,
			input logic [15:0] word);
		als_pkg::slave_s n;
		n = s;
		n.sda_oe_n = word[7];
		n.tx = {word[6:0], 1'b0};
		n.tx_hi = word[15:8];
		n.byte_hi = 1'b1;
		n.status_clear = (s.cmd == `CMD_STATUS);
		n.state = als_pkg::ST_RDATA;
		return n;
	endfunction : load_word

	// Commits a received word; read-only and unmapped codes keep nothing.
	function automatic als_pkg::slave_s reg_write(input als_pkg::slave_s s,
			input logic [15:0] word);
		als_pkg::slave_s n;
		n = s;
		if (s.cmd == `CMD_LIGHT_CONFIG) begin
			n.light_config = als_pkg::light_config_s'(word);
		end else if (s.cmd == `CMD_UPPER_BOUND) begin
			n.upper_window_bound = word;
		end else if (s.cmd == `CMD_LOWER_BOUND) begin
			n.lower_window_bound = word;
		end else if (s.cmd == `CMD_POWER_SAVING) begin
			n.power_saving_control = word[2:0];
		end
		return n;
	endfunction : reg_write

	assign raw_pins.scl = i_scl;
	assign raw_pins.sda = i_sda;

	// The 200 MHz sampling gives hundreds of samples per bit at 400 kHz.
	als_pin_sync u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_pins(raw_pins),
		.o_pins(pins)
	);

	als_measure u_measure (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_cfg(r.light_config),
		.i_upper_window_bound(r.upper_window_bound),
		.i_lower_window_bound(r.lower_window_bound),
		.i_sample(i_sample),
		.i_status_clear(r.status_clear),
		.o_result(result)
	);

	// Clock edges are found by comparing the synchronised pin with its last sample.
	assign scl_rise = pins.scl & ~r.scl_prev;
	assign scl_fall = ~pins.scl & r.scl_prev;
	// Start and stop are data edges while the clock stays high.
	assign start_seen = pins.scl & r.scl_prev & r.sda_prev & ~pins.sda;
	assign stop_seen = pins.scl & r.scl_prev & ~r.sda_prev & pins.sda;
	assign rd_word = reg_read(r.cmd, r, result);

	always_comb begin
		r_nxt = r;
		r_nxt.scl_prev = pins.scl;
		r_nxt.sda_prev = pins.sda;
		r_nxt.sda_out = 1'b0;
		r_nxt.status_clear = 1'b0;
		if (start_seen) begin
			// A start or repeated start expects an address, then a command code if the address byte is a write.
			r_nxt.state = als_pkg::ST_ADDR;
			r_nxt.bit_cnt = 4'h0;
			r_nxt.cmd_seen = 1'b0;
			r_nxt.byte_hi = 1'b0;
			r_nxt.sda_oe_n = 1'b1;
		end else if (stop_seen) begin
			r_nxt.state = als_pkg::ST_IDLE;
			r_nxt.sda_oe_n = 1'b1;
		end else begin
			case (r.state)
				als_pkg::ST_IDLE: begin
					r_nxt.sda_oe_n = 1'b1;
				end
				als_pkg::ST_ADDR: begin
					// Bits are taken on the rising clock, decisions on the falling one.
					if (scl_rise) begin
						r_nxt = shift_in(r_nxt, pins.sda);
					end else if (scl_fall && r.bit_cnt == `BYTE_BITS) begin
						if (r.shreg[7:1] == `SLAVE_ADDR) begin
							r_nxt.rw = r.shreg[0];
							r_nxt.sda_oe_n = 1'b0;
							r_nxt.state = als_pkg::ST_ADDR_ACK;
						end else begin
							r_nxt.state = als_pkg::ST_IDLE;
						end
					end
				end
				als_pkg::ST_ADDR_ACK: begin
					if (scl_fall) begin
						r_nxt.bit_cnt = 4'h0;
						if (r.rw) begin
							// The whole word is captured now so both bytes belong together.
							r_nxt = load_word(r_nxt, rd_word);
						end else begin
							r_nxt.sda_oe_n = 1'b1;
							r_nxt.state = als_pkg::ST_WDATA;
						end
					end
				end
				als_pkg::ST_WDATA: begin
					// The first byte is the command code, then low and high data bytes.
					if (scl_rise) begin
						r_nxt = shift_in(r_nxt, pins.sda);
					end else if (scl_fall && r.bit_cnt == `BYTE_BITS) begin
						r_nxt.sda_oe_n = 1'b0;
						r_nxt.state = als_pkg::ST_WDATA_ACK;
						if (!r.cmd_seen) begin
							r_nxt.cmd = r.shreg;
							r_nxt.cmd_seen = 1'b1;
							r_nxt.byte_hi = 1'b0;
						end else if (!r.byte_hi) begin
							r_nxt.wlow = r.shreg;
							r_nxt.byte_hi = 1'b1;
						end else begin
							r_nxt.byte_hi = 1'b0;
							// The word commits only with its high byte.
							r_nxt = reg_write(r_nxt, {r.shreg, r.wlow});
						end
					end
				end
				als_pkg::ST_WDATA_ACK: begin
					if (scl_fall) begin
						r_nxt.sda_oe_n = 1'b1;
						r_nxt.bit_cnt = 4'h0;
						r_nxt.state = als_pkg::ST_WDATA;
					end
				end
				als_pkg::ST_RDATA: begin
					if (scl_rise) begin
						r_nxt.bit_cnt = r.bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (r.bit_cnt == `BYTE_BITS) begin
							r_nxt.sda_oe_n = 1'b1;
							r_nxt.state = als_pkg::ST_RDATA_ACK;
						end else begin
							r_nxt.sda_oe_n = r.tx[7];
							r_nxt.tx = {r.tx[6:0], 1'b0};
						end
					end
				end
				als_pkg::ST_RDATA_ACK: begin
					if (scl_rise) begin
						r_nxt.shreg[0] = pins.sda;
					end else if (scl_fall) begin
						r_nxt.bit_cnt = 4'h0;
						if (r.shreg[0]) begin
							// A not-acknowledge ends the read until the next start.
							r_nxt.state = als_pkg::ST_IDLE;
						end else if (r.byte_hi) begin
							r_nxt.sda_oe_n = r.tx_hi[7];
							r_nxt.tx = {r.tx_hi[6:0], 1'b0};
							r_nxt.byte_hi = 1'b0;
							r_nxt.state = als_pkg::ST_RDATA;
						end else begin
							// A continued read takes a fresh snapshot of the same code.
							r_nxt = load_word(r_nxt, rd_word);
						end
					end
				end
				default: begin
					r_nxt.state = als_pkg::ST_IDLE;
					r_nxt.sda_oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r.state <= als_pkg::ST_IDLE;
			r.bit_cnt <= 4'h0;
			r.shreg <= 8'h00;
			r.rw <= 1'b0;
			r.cmd <= 8'h00;
			r.cmd_seen <= 1'b0;
			r.byte_hi <= 1'b0;
			r.wlow <= 8'h00;
			r.tx <= 8'h00;
			r.tx_hi <= 8'h00;
			r.sda_oe_n <= 1'b1;
			r.sda_out <= 1'b0;
			// Edge detectors start at the idle bus level so reset makes no false edge.
			r.scl_prev <= 1'b1;
			r.sda_prev <= 1'b1;
			r.status_clear <= 1'b0;
			r.light_config <= `LIGHT_CONFIG_RESET;
			r.upper_window_bound <= `WINDOW_BOUND_RESET;
			r.lower_window_bound <= `WINDOW_BOUND_RESET;
			r.power_saving_control <= `POWER_SAVING_RESET;
		end else begin
			r <= r_nxt;
		end
	end

	assign o_sda_out = r.sda_out;
	assign o_sda_oe_n = r.sda_oe_n;
	assign o_shutdown = r.light_config.shutdown_control;
	assign o_gain_select = r.light_config.gain_select;
	assign o_integration_time_select = r.light_config.integration_time_select;
	assign o_power_saving_select = r.power_saving_control.power_saving_select;
	assign o_power_saving_enable = r.power_saving_control.power_saving_enable;
endmodule : ambient_light_i2c_regs

//--- sim/als_regs_chk.sv
// Port assertions for the light sensor register interface.
`timescale 1ns/1ps
module als_regs_chk (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_scl,
	input wire logic o_sda_out,
	input wire logic o_sda_oe_n,
	input wire logic o_shutdown,
	input wire logic [1:0] o_gain_select,
	input wire logic [3:0] o_integration_time_select,
	input wire logic [1:0] o_power_saving_select,
	input wire logic o_power_saving_enable
);
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);
	sequence ack_now_s;
		!o_sda_oe_n && ($past(o_sda_oe_n) || $past(o_sda_oe_n, 2));
	endsequence
	sequence bit_hold_s;
		$stable(o_sda_oe_n) [*8];
	endsequence
	pin_low_a: assert property (!o_sda_out)
		else $error("data output not low");
	fall_timed_a: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl, 2))
		else $error("data enable moved with clock high");
	bit_hold_a: assert property ($changed(o_sda_oe_n) |=> bit_hold_s)
		else $error("data bit too short");
	reset_state_a: assert property ($rose(i_resetn) |-> o_shutdown && o_sda_oe_n)
		else $error("bad state after reset");
	gain_commit_a: assert property ($changed(o_gain_select) |-> ack_now_s)
		else $error("gain moved outside a commit");
	itime_commit_a: assert property ($changed(o_integration_time_select) |-> ack_now_s)
		else $error("time moved outside a commit");
	shut_commit_a: assert property ($changed(o_shutdown) |-> ack_now_s)
		else $error("shutdown moved outside a commit");
	psave_commit_a: assert property
		($changed({o_power_saving_select, o_power_saving_enable}) |-> ack_now_s)
		else $error("power saving moved outside a commit");
endmodule : als_regs_chk
bind ambient_light_i2c_regs als_regs_chk i_chk (
	.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_scl(i_scl),
	.o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_shutdown(o_shutdown),
	.o_gain_select(o_gain_select), .o_integration_time_select(o_integration_time_select),
	.o_power_saving_select(o_power_saving_select),
	.o_power_saving_enable(o_power_saving_enable)
);

//--- sim/i2c_host_model.sv
// Behavioural serial bus host that runs word transfers on the clock and data pins.
`timescale 1ns/1ps
module i2c_host_model (
	output logic o_scl,
	output logic o_sda,
	input wire logic i_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic put(input logic v);
		#12 o_sda = v;
		#12 o_scl = 1'b1;
		#24 o_scl = 1'b0;
	endtask : put
	task automatic get(output logic v);
		#12 o_sda = 1'b1;
		#12 o_scl = 1'b1;
		#12 v = i_sda;
		#12 o_scl = 1'b0;
	endtask : get
	task automatic start;
		#12 o_sda = 1'b1;
		#12 o_scl = 1'b1;
		#12 o_sda = 1'b0;
		#12 o_scl = 1'b0;
	endtask : start
	task automatic stop;
		#12 o_sda = 1'b0;
		#12 o_scl = 1'b1;
		#12 o_sda = 1'b1;
		#12;
	endtask : stop
	task automatic send(input logic [7:0] b, output logic nack);
		for (int i = 7; i >= 0; i--)
			put(b[i]);
		get(nack);
	endtask : send
	task automatic recv(output logic [7:0] b, input logic last);
		for (int i = 7; i >= 0; i--)
			get(b[i]);
		put(last);
	endtask : recv
	task automatic write_word(input logic [7:0] adr, input logic [7:0] cmd,
		input logic [15:0] d, output logic nack);
		logic n;
		start();
		send(adr, nack);
		send(cmd, n);
		send(d[7:0], n);
		send(d[15:8], n);
		stop();
	endtask : write_word
	task automatic read_word(input logic [7:0] cmd, output logic [15:0] d);
		logic n;
		start();
		send(8'h20, n);
		send(cmd, n);
		start();
		send(8'h21, n);
		recv(d[7:0], 1'b0);
		recv(d[15:8], 1'b1);
		stop();
	endtask : read_word
endmodule : i2c_host_model

//--- sim/testbench.sv
// Self-checking bench for the light sensor register interface and result handling.
`timescale 1ns/1ps
module testbench;
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic host_scl;
	logic host_sda;
	wire logic sda_w;
	logic o_sda_out;
	logic o_sda_oe_n;
	als_pkg::sample_s i_sample = '0;
	logic o_shutdown;
	logic [1:0] o_gain_select;
	logic [3:0] o_integration_time_select;
	logic [1:0] o_power_saving_select;
	logic o_power_saving_enable;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [15:0] d;
	logic [15:0] v;
	logic a;
	logic [3:0] it_tab [6] = '{4'hc, 4'h8, 4'h0, 4'h1, 4'h2, 4'h3};
	always #2.5 i_sys_clk = ~i_sys_clk;
	assign sda_w = host_sda & (o_sda_oe_n | o_sda_out);
	i2c_host_model i_host (.o_scl(host_scl), .o_sda(host_sda), .i_sda(sda_w));
	// The identification codes are arbitrary.
	ambient_light_i2c_regs #(.DEVICE_CODE(8'h6b), .ADDR_OPTION_CODE(8'h2e)) i_dut (
		.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_scl(host_scl), .i_sda(sda_w),
		.o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .i_sample(i_sample),
		.o_shutdown(o_shutdown), .o_gain_select(o_gain_select),
		.o_integration_time_select(o_integration_time_select),
		.o_power_saving_select(o_power_saving_select),
		.o_power_saving_enable(o_power_saving_enable)
	);
	function automatic logic [15:0] cfg_of(input int i);
		logic [1:0] g;
		g = i[1:0];
		return {3'h0, g, 1'b0, it_tab[i], g, 2'h0, 1'b0, g[0]};
	endfunction : cfg_of
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] cmd, input logic [15:0] val);
		i_host.write_word(8'h20, cmd, val, a);
	endtask : wr
	task automatic rdc(input string name, input logic [7:0] cmd, input logic [15:0] exp);
		i_host.read_word(cmd, d);
		chk(name, d, exp);
	endtask : rdc
	task automatic samp(input logic [15:0] amb, input logic [15:0] wht);
		@(negedge i_sys_clk);
		i_sample = {1'b1, amb, wht};
		@(negedge i_sys_clk);
		i_sample.valid = 1'b0;
	endtask : samp
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_fail++;
			stop_test();
		end
	end
	initial begin
		v = 16'($urandom(32'hf2026347));
		repeat (3) @(negedge i_sys_clk);
		i_resetn = 1'b1;
		repeat (4) @(negedge i_sys_clk);
		chk("shut_rst", 16'(o_shutdown), 16'h0001);
		rdc("cfg_rst", 8'h00, 16'h0001);
		i_host.write_word(8'h22, 8'h01, 16'h1234, a);
		chk("bad_addr_ack", 16'(a), 16'h0001);
		rdc("upper_kept", 8'h01, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			wr(8'h00, cfg_of(i));
			chk("gain", 16'(o_gain_select), 16'(i[1:0]));
			chk("itime", 16'(o_integration_time_select), 16'(it_tab[i]));
			chk("shut", 16'(o_shutdown), 16'(i[0]));
			rdc("cfg", 8'h00, cfg_of(i));
			v = 16'($urandom);
			wr(8'h01, v);
			rdc("upper", 8'h01, v);
			v = 16'($urandom);
			wr(8'h02, v);
			rdc("lower", 8'h02, v);
			v = 16'($urandom & 32'h7);
			wr(8'h03, v);
			rdc("psave", 8'h03, v);
			chk("ps_pins", 16'({o_power_saving_select, o_power_saving_enable}), v);
		end
		wr(8'h01, 16'h1000);
		wr(8'h02, 16'h0100);
		wr(8'h00, 16'h0010);
		samp(16'h2000, 16'h0abc);
		samp(16'h2000, 16'h0abc);
		rdc("no_detect", 8'h06, 16'h0000);
		wr(8'h00, 16'h0012);
		samp(16'h2000, 16'h0abc);
		rdc("one_high", 8'h06, 16'h0000);
		samp(16'h2000, 16'h0abc);
		rdc("high_flag", 8'h06, 16'h4000);
		rdc("ambient", 8'h04, 16'h2000);
		rdc("white", 8'h05, 16'h0abc);
		samp(16'h0050, 16'h0001);
		samp(16'h0050, 16'h0001);
		rdc("low_flag", 8'h06, 16'h8000);
		wr(8'h04, 16'hffff);
		wr(8'h07, 16'hffff);
		rdc("ro_kept", 8'h04, 16'h0050);
		rdc("ident", 8'h07, 16'h2e6b);
		rdc("unmapped", 8'h09, 16'h0000);
		wr(8'h00, 16'h0013);
		samp(16'h0777, 16'h0777);
		rdc("held", 8'h04, 16'h0050);
		wr(8'h00, 16'h0012);
		samp(16'h0777, 16'h0777);
		rdc("fresh", 8'h04, 16'h0777);
		stop_test();
	end
endmodule : testbench
